// [core/rx_sync_bist_status_regs.svh]
// Constants for the receive synchronization and self-test status block
`ifndef RX_SYNC_BIST_STATUS_REGS_SVH
`define RX_SYNC_BIST_STATUS_REGS_SVH
`define ST_DATA        3'h0
`define ST_SPECIAL     3'h1
`define ST_LOCK        3'h2
`define ST_FRAME       3'h3
`define ST_CODE_VIOL   3'h4
`define ST_LOST_SYNC   3'h5
`define ST_DISPARITY   3'h6
`define ST_RESYNC      3'h7
`define BT_BEGIN       3'h7
`define BT_WAIT        3'h5
`define BT_MATCH       3'h0
`define BT_ERROR       3'h4
`define BT_LAST        3'h2
`define FRAMES_TO_LOCK 3'h4
`define DEC_ERR_LIMIT  3'h4
`define INV_EXCESS_MAX 5'h04
`define BIST_EXCESS    6'h10
`define RECENTRE_CYC   4'h9
`define DESKEW_CYC     8'h10
`define FIFO_DEPTH     8
`define FIFO_WIDTH     12
`endif

// [core/rx_status_pkg.sv]
// Types for the receive synchronization and self-test status block
package rx_status_pkg;
  typedef enum logic [4:0] {
    SYNC_NONE      = 5'h01,
    SYNC_RESYNC    = 5'h02,
    SYNC_BOND_FAIL = 5'h04,
    SYNC_LOCKED    = 5'h08,
    SYNC_RELOCK    = 5'h10
  } sync_state_e;
  typedef enum logic [2:0] {
    BIST_BEGIN = 3'h1,
    BIST_AWAIT = 3'h2,
    BIST_RUN   = 3'h4
  } bist_state_e;
  typedef struct packed {
    sync_state_e sync;
    logic [2:0]  frames;
    logic [2:0]  dec_errs;
    logic [4:0]  inv_excess;
    logic [7:0]  deskew;
    bist_state_e bist;
    logic [5:0]  bist_excess;
    logic [3:0]  recentre;
    logic        lock_shown;
  } status_state_s;
endpackage

// [core/status_fifo.sv]
// Small valid/ready FIFO with registered read data
`timescale 1ns/1ps
module status_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  // Output register mirrors the head and adds no extra slot
  assign out_valid = (count != '0);
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      out_data <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
      // Read data register always shows the head
      if (pop && count > (AW+1)'(1)) begin
        out_data <= mem[rd_ptr + 1'b1];
      end else if (push && (count == '0 || (pop && count == (AW+1)'(1)))) begin
        out_data <= in_data;
      end
    end
  end
endmodule // status_fifo

// [core/rx_sync_bist_status.sv]
// Receive channel status: synchronization, self-test status and output staging
//
// Function
// RULE1 - Type-A machine: no-sync, resync, bond-failed, in-sync; only in-sync varies code.
// RULE2 - Type-B machine: no-sync, resync, in-sync, resync-in-sync states.
// RULE3 - Low mode bit picks Type-A or Type-B; self-test gets its own reporting.
// RULE4 - During self-test compare, status reports compare state instead of data status.
// RULE5 - Receive PLL lock loss forces self-test machine to its begin state.
// RULE6 - Errors exceeding matches by over 16 send self-test to await D0.0.
// RULE7 - Buffer over/underflow holds self-test begin state about nine characters.
// RULE8 - Both link ends use the same receive clock selection class.
// RULE9 - Parity outputs are not driven while parity control is low.
// RULE10 - Decoder bypass without self-test: status bit 2 low except framing characters.
// RULE11 - Bonded mode reports 000 for valid data characters.
// RULE12 - Bonded mode reports 001 for special characters other than framing.
// RULE13 - Type-B reports 010 once bonded channels resync, on last cycle only.
// RULE14 - Framing character reports 011 with its decoded value on the bus.
// RULE15 - Disparity error reports 110; resync reports 111 with framing character shown.
// RULE16 - Four consecutive framing characters move resync to in-sync.
// RULE17 - Leave in-sync on buffer fault, lock loss, four decoder errors, excess four.
// RULE18 - Machine runs only when bonding mode bit is set; else decode directly.
// RULE19 - Status is registered together with its character, always aligned.
`timescale 1ns/1ps
`include "rx_sync_bist_status_regs.svh"
module rx_sync_bist_status (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] rx_mode_select,
  input  wire logic       decoder_mode,
  input  wire logic [1:0] parity_control,
  input  wire logic       bist_enable,
  input  wire logic       char_valid,
  input  wire logic [7:0] char_data,
  input  wire logic [1:0] raw_low_bits,
  input  wire logic       char_special,
  input  wire logic       char_framing,
  input  wire logic       char_code_viol,
  input  wire logic       char_disparity,
  input  wire logic       bist_match,
  input  wire logic       bist_error,
  input  wire logic       bist_last,
  input  wire logic       pll_lock_lost,
  input  wire logic       ebuf_fault,
  input  wire logic       bond_all_resync,
  output logic            char_ready,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic [7:0]      rx_data,
  output logic [2:0]      rx_char_status,
  output logic            rx_parity_out,
  output logic            rx_parity_oe,
  output logic            sync_locked
);
  // ****************************************
  // Shared decode
  // ****************************************
  rx_status_pkg::status_state_s state;
  rx_status_pkg::status_state_s next_state;
  logic                         bonded;
  logic                         any_dec_err;
  logic                         bist_on;
  logic [2:0]                   status_code;
  logic [7:0]                   data_code;
  logic                         fifo_ready;
  logic [11:0]                  fifo_out;
  logic                         take;

  function automatic logic [2:0] char_class(input logic viol, input logic disp,
                                            input logic frame, input logic spec);
    if (viol) begin
      char_class = `ST_CODE_VIOL;
    end else if (disp) begin
      char_class = `ST_DISPARITY;                                  // RULE15
    end else if (frame) begin
      char_class = `ST_FRAME;                                      // RULE14
    end else if (spec) begin
      char_class = `ST_SPECIAL;                                    // RULE12
    end else begin
      char_class = `ST_DATA;                                       // RULE11
    end
  endfunction

  assign bonded      = rx_mode_select[1];                          // RULE18
  assign bist_on     = bist_enable;
  assign any_dec_err = char_code_viol || char_disparity;
  assign take        = char_valid && fifo_ready;
  assign char_ready  = fifo_ready;

  // ****************************************
  // State machines
  // ****************************************
  always_comb begin
    next_state = state;
    if (take && bonded && !bist_on) begin                          // RULE18
      next_state.lock_shown = 1'b0;
      case (state.sync)
        rx_status_pkg::SYNC_NONE: begin
          if (char_framing) begin
            next_state.sync   = rx_status_pkg::SYNC_RESYNC;
            next_state.frames = 3'h1;
          end
        end
        rx_status_pkg::SYNC_RESYNC, rx_status_pkg::SYNC_RELOCK: begin
          if (pll_lock_lost || ebuf_fault || any_dec_err) begin
            next_state.sync   = rx_status_pkg::SYNC_NONE;
            next_state.frames = '0;
          end else if (char_framing) begin
            next_state.frames = state.frames + 3'h1;
            if (state.frames + 3'h1 >= `FRAMES_TO_LOCK) begin        // RULE16
              next_state.sync       = rx_status_pkg::SYNC_LOCKED;
              next_state.dec_errs   = '0;
              next_state.inv_excess = '0;
              next_state.lock_shown = rx_mode_select[0];           // RULE13
            end
          end else begin
            next_state.frames = '0;
          end
          if (!rx_mode_select[0] && state.sync == rx_status_pkg::SYNC_RESYNC) begin
            next_state.deskew = state.deskew + 8'h01;
            if (state.deskew == `DESKEW_CYC && !bond_all_resync) begin
              next_state.sync = rx_status_pkg::SYNC_BOND_FAIL;     // RULE1
            end
          end
        end
        rx_status_pkg::SYNC_BOND_FAIL: begin
          if (char_framing) begin
            next_state.sync   = rx_status_pkg::SYNC_RESYNC;
            next_state.deskew = '0;
          end
        end
        rx_status_pkg::SYNC_LOCKED: begin
          next_state.dec_errs = any_dec_err ? state.dec_errs + 3'h1 : 3'h0;
          if (any_dec_err) begin
            next_state.inv_excess = state.inv_excess + 5'h01;
          end else if (state.inv_excess != '0) begin
            next_state.inv_excess = state.inv_excess - 5'h01;
          end
          if (pll_lock_lost || ebuf_fault || next_state.dec_errs == `DEC_ERR_LIMIT ||
              next_state.inv_excess == `INV_EXCESS_MAX) begin    // RULE17
            next_state.sync = rx_mode_select[0] ? rx_status_pkg::SYNC_RELOCK // RULE2
                                                : rx_status_pkg::SYNC_NONE;
            next_state.frames = '0;
            next_state.deskew = '0;
          end
        end
        default: begin
          next_state.sync = rx_status_pkg::SYNC_NONE;
        end
      endcase
    end
    if (take && bist_on) begin                                     // RULE4
      case (state.bist)
        rx_status_pkg::BIST_BEGIN: begin
          if (state.recentre == '0 && char_data == 8'h00 && !char_special) begin
            next_state.bist        = rx_status_pkg::BIST_RUN;
            next_state.bist_excess = '0;
          end
        end
        rx_status_pkg::BIST_AWAIT: begin
          if (char_data == 8'h00 && !char_special) begin           // RULE6
            next_state.bist        = rx_status_pkg::BIST_RUN;
            next_state.bist_excess = '0;
          end
        end
        rx_status_pkg::BIST_RUN: begin
          if (bist_error) begin
            next_state.bist_excess = state.bist_excess + 6'h01;
          end else if (bist_match && state.bist_excess != '0) begin
            next_state.bist_excess = state.bist_excess - 6'h01;
          end
          if (bist_error && state.bist_excess == `BIST_EXCESS) begin
            next_state.bist = rx_status_pkg::BIST_AWAIT;           // RULE6
          end
        end
        default: begin
          next_state.bist = rx_status_pkg::BIST_BEGIN;
        end
      endcase
    end
    if (state.recentre != '0) begin
      next_state.recentre = state.recentre - 4'h1;
    end
    if (ebuf_fault) begin
      next_state.bist     = rx_status_pkg::BIST_BEGIN;             // RULE7
      next_state.recentre = `RECENTRE_CYC;                         // RULE7
    end
    if (pll_lock_lost) begin
      next_state.bist = rx_status_pkg::BIST_BEGIN;                 // RULE5
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= '{sync: rx_status_pkg::SYNC_NONE, frames: '0, dec_errs: '0,
                 inv_excess: '0, deskew: '0, bist: rx_status_pkg::BIST_BEGIN,
                 bist_excess: '0, recentre: '0, lock_shown: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Status encoding
  // ****************************************
  always_comb begin
    data_code   = char_data;
    status_code = char_class(char_code_viol, char_disparity, char_framing, char_special);
    if (bist_on) begin                                             // RULE3
      if (state.bist != rx_status_pkg::BIST_RUN) begin
        status_code = (state.bist == rx_status_pkg::BIST_AWAIT) ? `BT_WAIT : `BT_BEGIN;
      end else if (bist_error) begin
        status_code = `BT_ERROR;
      end else if (bist_last) begin
        status_code = `BT_LAST;
      end else begin
        status_code = `BT_MATCH;
      end
    end else if (!decoder_mode) begin
      status_code = {char_framing, raw_low_bits};                  // RULE10
    end else if (bonded) begin
      case (state.sync)
        rx_status_pkg::SYNC_NONE, rx_status_pkg::SYNC_BOND_FAIL: begin
          status_code = `ST_LOST_SYNC;                             // RULE1
        end
        rx_status_pkg::SYNC_RESYNC, rx_status_pkg::SYNC_RELOCK: begin
          status_code = `ST_RESYNC;                                // RULE15
        end
        rx_status_pkg::SYNC_LOCKED: begin
          if (rx_mode_select[0] && state.lock_shown) begin
            status_code = `ST_LOCK;                                // RULE13
          end
        end
        default: begin
          status_code = `ST_LOST_SYNC;
        end
      endcase
    end
  end

  // ****************************************
  // Output staging
  // ****************************************
  status_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (char_valid),
    .in_ready  (fifo_ready),
    .in_data   ({sync_locked_next(state.sync), status_code, data_code}), // RULE19
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out)
  );

  function automatic logic sync_locked_next(input rx_status_pkg::sync_state_e s);
    sync_locked_next = (s == rx_status_pkg::SYNC_LOCKED);
  endfunction

  assign rx_data        = fifo_out[7:0];
  assign rx_char_status = fifo_out[10:8];
  assign sync_locked    = fifo_out[11];
  // Odd parity over the bits the control selects
  assign rx_parity_out  = ~(^rx_data ^
                            ((parity_control != 2'h0 && !decoder_mode) ||
                             parity_control == 2'h3 ? ^rx_char_status[1:0] : 1'b0) ^
                            (parity_control == 2'h3 ? rx_char_status[2] : 1'b0));
  assign rx_parity_oe   = (parity_control != 2'h0);                // RULE9
endmodule // rx_sync_bist_status

// [bench/rx_sync_bist_status_assertions.sv]
// Port checker for the receive status block
`timescale 1ns/1ps
module rx_status_checker (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [1:0] parity_control,
  input wire logic       decoder_mode,
  input wire logic       bist_enable,
  input wire logic       char_valid,
  input wire logic       char_ready,
  input wire logic       pll_lock_lost,
  input wire logic       ebuf_fault,
  input wire logic       out_valid,
  input wire logic       out_ready,
  input wire logic [7:0] rx_data,
  input wire logic [2:0] rx_char_status,
  input wire logic       rx_parity_out,
  input wire logic       rx_parity_oe
);
  logic [3:0] occ;
  logic [3:0] since_fault;
  logic       take;
  assign take = char_valid && char_ready;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      occ         <= 4'h0;
      since_fault <= 4'hF;
    end else begin
      occ         <= occ + 4'(take) - 4'(out_valid && out_ready);
      since_fault <= ebuf_fault ? 4'h1 : (since_fault == 4'hF ? 4'hF : since_fault + 4'h1);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_parity_hiz: assert property (rx_parity_oe == (parity_control != 2'h0))
    else $error("parity enable wrong");
  a_parity_high: assert property (out_valid && parity_control == 2'h3
    |-> ^{rx_data, rx_char_status, rx_parity_out}) else $error("parity high wrong");
  a_parity_mid: assert property (out_valid && parity_control == 2'h1 && decoder_mode
    |-> ^{rx_data, rx_parity_out}) else $error("parity mid wrong");
  a_head_hold: assert property (out_valid && !out_ready
    |=> out_valid && $stable(rx_data) && $stable(rx_char_status)) else $error("head moved");
  a_valid_occ: assert property (out_valid == (occ != 4'h0))
    else $error("valid wrong");
  a_ready_full: assert property (char_ready == (occ != 4'h8)) else $error("ready wrong");
  a_lock_begin: assert property (bist_enable && $past(pll_lock_lost) && take
    && occ == 4'h0 |=> rx_char_status == 3'h7) else $error("lock loss not begin");
  a_recentre_hold: assert property (bist_enable && take && occ == 4'h0
    && since_fault inside {[4'h1:4'h8]} |=> rx_char_status == 3'h7) else $error("no hold");
  c_full: cover property (char_valid && !char_ready);
  c_lock: cover property (bist_enable && pll_lock_lost);
  c_fault: cover property (bist_enable && ebuf_fault);
endmodule // rx_status_checker
bind rx_sync_bist_status rx_status_checker chk (.sys_clk, .rst_n, .parity_control,
  .decoder_mode, .bist_enable, .char_valid, .char_ready, .pll_lock_lost, .ebuf_fault,
  .out_valid, .out_ready, .rx_data, .rx_char_status, .rx_parity_out, .rx_parity_oe);

// [bench/rx_sink_model.sv]
// Consumer of received characters with stall and slow modes
`timescale 1ns/1ps
module rx_sink_model #(
  parameter bit CLOCK_CLASS_MID = 1'b1
) (
  input wire logic sys_clk,
  input wire logic stall,
  input wire logic slow,
  output logic     out_ready
);
  initial out_ready = 1'b0;
  always @(posedge sys_clk) begin
    #1 out_ready = !stall && (!slow || $urandom_range(1, 0) == 1);
  end
endmodule // rx_sink_model

// [bench/rx_sync_bist_status_bench.sv]
// Self-checking bench for the receive status block
`timescale 1ns/1ps
module rx_sync_bist_status_bench;
  typedef struct packed {
    logic [7:0] d;
    logic [2:0] st;
    logic       cs;
    logic       lk;
    logic       cl;
  } note_s;
  logic       sys_clk = 1'b0, rst_n = 1'b0, decoder_mode = 1'b1, bist_enable = 1'b0;
  logic       char_valid = 1'b0, char_special = 1'b0, char_framing = 1'b0;
  logic       char_code_viol = 1'b0, char_disparity = 1'b0, bist_match = 1'b0;
  logic       pll_lock_lost = 1'b0, ebuf_fault = 1'b0, stall = 1'b1, slow = 1'b0;
  logic       bist_error = 1'b0, bist_last = 1'b0;
  logic [1:0] rx_mode_select = 2'h0, parity_control = 2'h0, raw_low_bits = 2'h0;
  logic [7:0] char_data = 8'h00, rx_data;
  logic [2:0] rx_char_status;
  logic       char_ready, out_valid, out_ready, rx_parity_out, rx_parity_oe, sync_locked;
  note_s      notes[$];
  note_s      n;
  int         n_mismatch = 0, n_tests = 0, cyc = 0, i;
  logic [1:0] f;
  always #4 sys_clk = ~sys_clk;
  rx_sync_bist_status uut (.sys_clk, .rst_n, .rx_mode_select, .decoder_mode,
    .parity_control, .bist_enable, .char_valid, .char_data, .raw_low_bits, .char_special,
    .char_framing, .char_code_viol, .char_disparity, .bist_match, .bist_error,
    .bist_last, .pll_lock_lost, .ebuf_fault, .bond_all_resync(1'b0), .char_ready,
    .out_valid, .out_ready, .rx_data, .rx_char_status, .rx_parity_out, .rx_parity_oe,
    .sync_locked);
  rx_sink_model sink (.sys_clk, .stall, .slow, .out_ready);
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %0s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic do_reset();
    #1 rst_n = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    @(posedge sys_clk);
  endtask
  // Kind is {special, framing, violation, disparity}
  task automatic send(input logic [7:0] d, input logic [3:0] k, input logic [1:0] raw,
                      input logic [2:0] st, input logic cs, input logic lk, input logic cl);
    int w;
    w = 0;
    #1 char_valid = 1'b1;
    char_data = d;
    {char_special, char_framing, char_code_viol, char_disparity} = k;
    raw_low_bits = raw;
    while (!char_ready && w < 100) begin
      @(posedge sys_clk);
      #1 w++;
    end
    if (w == 100) n_mismatch++;
    notes.push_back('{d, st, cs, lk, cl});
    @(posedge sys_clk);
  endtask
  task automatic end_test(input string name);
    int w;
    w = 0;
    #1 char_valid = 1'b0;
    while (notes.size() != 0 && w < 500) begin
      @(posedge sys_clk);
      w++;
    end
    if (w == 500) n_mismatch++;
    $display("test %0s finished", name);
  endtask
  // Scoreboard: compare each popped character with the oldest note
  always @(posedge sys_clk) begin
    if (rst_n && out_valid && out_ready) begin
      if (notes.size() == 0) n_mismatch++;
      else begin
        n = notes.pop_front();
        check("rx_data", rx_data, n.d);
        if (n.cs) check("rx_char_status", 8'(rx_char_status), 8'(n.st));
        if (n.cl) check("sync_locked", 8'(sync_locked), 8'(n.lk));
      end
    end
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(4123));
    do_reset();
    parity_control = 2'h1;
    for (i = 0; i < 8; i++) send(8'($urandom), 4'h0, 2'h0, 3'h0, 1'b1, 1'b0, 1'b0);
    #2 check("char_ready", 8'(char_ready), 8'h00);
    char_valid = 1'b0;
    @(posedge sys_clk);
    stall = 1'b0;
    slow = 1'b1;
    send(8'h5A, 4'h8, 2'h0, 3'h1, 1'b1, 1'b0, 1'b0);
    send(8'hBC, 4'h4, 2'h0, 3'h3, 1'b1, 1'b0, 1'b0);
    send(8'h21, 4'h2, 2'h0, 3'h4, 1'b1, 1'b0, 1'b0);
    send(8'h33, 4'h1, 2'h0, 3'h6, 1'b1, 1'b0, 1'b0);
    end_test("fifo_and_kinds");
    do_reset();
    parity_control = 2'h3;
    rx_mode_select = 2'h2;
    send(8'hBC, 4'h4, 2'h0, 3'h0, 1'b0, 1'b0, 1'b0);
    repeat (3) send(8'hBC, 4'h4, 2'h0, 3'h7, 1'b1, 1'b0, 1'b0);
    send(8'hBC, 4'h4, 2'h0, 3'h0, 1'b0, 1'b0, 1'b0);
    send(8'hBC, 4'h4, 2'h0, 3'h3, 1'b1, 1'b1, 1'b1);
    send(8'($urandom), 4'h0, 2'h0, 3'h0, 1'b1, 1'b1, 1'b1);
    send(8'($urandom), 4'h8, 2'h0, 3'h1, 1'b1, 1'b1, 1'b1);
    repeat (4) send(8'($urandom), 4'h2, 2'h0, 3'h4, 1'b1, 1'b0, 1'b0);
    send(8'($urandom), 4'h0, 2'h0, 3'h0, 1'b0, 1'b0, 1'b1);
    end_test("bonded_type_a");
    do_reset();
    rx_mode_select = 2'h3;
    send(8'hBC, 4'h4, 2'h0, 3'h5, 1'b1, 1'b0, 1'b1);
    repeat (3) send(8'hBC, 4'h4, 2'h0, 3'h7, 1'b1, 1'b0, 1'b1);
    send(8'hBC, 4'h4, 2'h0, 3'h2, 1'b1, 1'b1, 1'b1);
    send(8'hBC, 4'h4, 2'h0, 3'h3, 1'b1, 1'b1, 1'b1);
    repeat (4) send(8'($urandom), 4'h2, 2'h0, 3'h4, 1'b1, 1'b1, 1'b1);
    send(8'h42, 4'h0, 2'h0, 3'h7, 1'b1, 1'b0, 1'b1);
    end_test("bonded_type_b");
    do_reset();
    parity_control = 2'h0;
    rx_mode_select = 2'h0;
    decoder_mode = 1'b0;
    for (i = 0; i < 8; i++) begin
      f = 2'($urandom);
      send(8'($urandom), {1'b0, f[0], 2'h0}, f, {f[0], f}, 1'b1, 1'b0, 1'b0);
    end
    end_test("bypass");
    do_reset();
    parity_control = 2'h1;
    decoder_mode = 1'b1;
    bist_enable = 1'b1;
    bist_match = 1'b1;
    slow = 1'b0;
    #1 pll_lock_lost = 1'b1;
    @(posedge sys_clk);
    #1 pll_lock_lost = 1'b0;
    send(8'h00, 4'h0, 2'h0, 3'h7, 1'b1, 1'b0, 1'b0);
    #1 char_valid = 1'b0;
    ebuf_fault = 1'b1;
    @(posedge sys_clk);
    #1 ebuf_fault = 1'b0;
    repeat (3) send(8'h00, 4'h0, 2'h0, 3'h7, 1'b1, 1'b0, 1'b0);
    #1 char_valid = 1'b0;
    repeat (10) @(posedge sys_clk);
    send(8'h00, 4'h0, 2'h0, 3'h7, 1'b1, 1'b0, 1'b0);
    send(8'h55, 4'h0, 2'h0, 3'h0, 1'b1, 1'b0, 1'b0);
    #1 bist_error = 1'b1;
    repeat (17) send(8'h55, 4'h0, 2'h0, 3'h4, 1'b1, 1'b0, 1'b0);
    #1 bist_error = 1'b0;
    send(8'h55, 4'h0, 2'h0, 3'h5, 1'b1, 1'b0, 1'b0);
    send(8'h00, 4'h0, 2'h0, 3'h5, 1'b1, 1'b0, 1'b0);
    #1 bist_last = 1'b1;
    send(8'h11, 4'h0, 2'h0, 3'h2, 1'b1, 1'b0, 1'b0);
    #1 bist_last = 1'b0;
    end_test("selftest");
    tally_and_finish();
  end
endmodule // rx_sync_bist_status_bench
